//--- core/seq_pkg.sv
// constants, types and register map of the conversion sequencer
// Overview of operation
// RULE1: ten-bit successive approximation result per conversion
// RULE2: single mode start bit holds, then self-clears
// RULE3: single end stores, flags, clears start, idles
// RULE4: flag with enable raises end interrupt
// RULE5: flag clears only by read, then zero write
// RULE6: software halts before changing mode or channel
// RULE7: scan begins at group's first input
// RULE8: scan cycles selected channels until halted
// RULE9: scan results go to paired registers
// RULE10: scan sets flag per pass, restarts at once
// RULE11: restart after halt begins at first channel
// RULE12: sampling delay 10-17 or 6-9 states
// RULE13: sampling lasts 80 or 40 states
// RULE14: first conversion 259-266 or 131-134 states
// RULE15: later scan conversions exactly 256 or 128 states
// RULE16: enabled trigger falling edge sets start bit
// RULE17: channel bits and scan choose the inputs
// RULE18: result high byte, two low bits, zeros
// RULE19: high byte read latches low byte
// RULE20: trigger synchronised, one start per edge
// RULE21: interrupt is level of flag and enable
package seq_pkg;
    localparam int RES_W = 10;
    localparam int CNT_W = 9;
    typedef logic [CNT_W-1:0] cnt_t;
    typedef logic [RES_W-1:0] res_t;

    localparam int CLK_NS = 100;
    localparam int STATE_NS = 100;
    localparam int CYC_PER_STATE = STATE_NS / CLK_NS;

    localparam int SYNC_MIN_SLOW_ST = 10;
    localparam int SYNC_MAX_SLOW_ST = 17;
    localparam int SYNC_MIN_FAST_ST = 6;
    localparam int SYNC_MAX_FAST_ST = 9;
    localparam int SPL_SLOW_ST = 80;
    localparam int SPL_FAST_ST = 40;
    localparam int CONV_MIN_SLOW_ST = 259;
    localparam int CONV_MAX_SLOW_ST = 266;
    localparam int CONV_MIN_FAST_ST = 131;
    localparam int CONV_MAX_FAST_ST = 134;
    localparam int CONV_LATER_SLOW_ST = 256;
    localparam int CONV_LATER_FAST_ST = 128;

    localparam int SYNC_MIN_SLOW = SYNC_MIN_SLOW_ST * CYC_PER_STATE;
    localparam int SYNC_MAX_SLOW = SYNC_MAX_SLOW_ST * CYC_PER_STATE;
    localparam int SYNC_MIN_FAST = SYNC_MIN_FAST_ST * CYC_PER_STATE;
    localparam int SYNC_MAX_FAST = SYNC_MAX_FAST_ST * CYC_PER_STATE;
    localparam int SPL_SLOW = SPL_SLOW_ST * CYC_PER_STATE;
    localparam int SPL_FAST = SPL_FAST_ST * CYC_PER_STATE;
    localparam int CONV_MIN_SLOW = CONV_MIN_SLOW_ST * CYC_PER_STATE;
    localparam int CONV_MAX_SLOW = CONV_MAX_SLOW_ST * CYC_PER_STATE;
    localparam int CONV_MIN_FAST = CONV_MIN_FAST_ST * CYC_PER_STATE;
    localparam int CONV_MAX_FAST = CONV_MAX_FAST_ST * CYC_PER_STATE;
    localparam int LATER_SLOW = CONV_LATER_SLOW_ST * CYC_PER_STATE;
    localparam int LATER_FAST = CONV_LATER_FAST_ST * CYC_PER_STATE;
    // conversion tail after sampling, first and later conversions
    localparam int TAIL_FIRST_SLOW = CONV_MIN_SLOW - SYNC_MIN_SLOW - SPL_SLOW;
    localparam int TAIL_FIRST_FAST = CONV_MIN_FAST - SYNC_MIN_FAST - SPL_FAST;
    localparam int TAIL_LATER_SLOW = LATER_SLOW - SPL_SLOW;
    localparam int TAIL_LATER_FAST = LATER_FAST - SPL_FAST;
    localparam cnt_t STEP_MASK_SLOW = 9'h00f;
    localparam cnt_t STEP_MASK_FAST = 9'h007;

    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_RESULT_A = 8'he0;
    localparam logic [7:0] IDX_CSR = 8'he8;
    localparam logic [7:0] IDX_TRIG = 8'he9;
    localparam int CSR_FLAG = 7;
    localparam int CSR_IE = 6;
    localparam int CSR_START = 5;
    localparam int CSR_SCAN = 4;
    localparam int CSR_CKS = 3;
    localparam int TRIG_ENABLE = 7;
    localparam logic [6:0] TRIG_RSVD = 7'h7f;
    localparam logic [5:0] RESULT_PAD = 6'h00;
    localparam res_t RESULT_RESET = 10'h000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SYNC = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_CONVERT = 2'b11
    } state_t;

    function automatic logic is_result(input logic [7:0] idx);
        return idx[7:3] == IDX_RESULT_A[7:3];
    endfunction
endpackage

//--- core/sar_if.sv
// trial handshake between the sequencer and the approximation engine
interface sar_if;
    logic trial_start;
    logic trial_step;
    logic cmp_above;
    seq_pkg::res_t dac_code;
    modport ctrl (output trial_start, output trial_step, output cmp_above, input dac_code);
    modport engine (input trial_start, input trial_step, input cmp_above, output dac_code);
endinterface

//--- core/pin_sync.sv
// three-flop pin synchroniser with agreement filter and fall detect
module pin_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic pin,
    output logic level,
    output logic fell
);
    logic [2:0] sync_reg;
    logic level_reg;
    logic fell_reg;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync_reg <= 3'h7;
            level_reg <= 1'b1;
            fell_reg <= 1'b0;
        end
        else
        begin
            sync_reg <= {sync_reg[1:0], pin};
            if (sync_reg[1] == sync_reg[2])
                level_reg <= sync_reg[2];
            fell_reg <= level_reg & (sync_reg[1] == sync_reg[2]) & ~sync_reg[2]; // [RULE20]
        end
    end

    assign level = level_reg;
    assign fell = fell_reg;

    property p_fell_once;
        @(posedge clk) disable iff (srst) fell_reg |-> !level_reg ##1 !fell_reg;
    endproperty
    a_fell_once: assert property (p_fell_once) else $error("fall pulse repeated"); // [RULE20]
endmodule // pin_sync

//--- core/sar_engine.sv
// successive approximation register: one trial bit per step
module sar_engine (
    input wire logic clk,
    input wire logic srst,
    sar_if.engine sar
);
    localparam seq_pkg::res_t MSB = 10'h200;
    seq_pkg::res_t code_reg;
    seq_pkg::res_t trial_reg;

    // a step after the last bit is ignored, so spare steps are harmless
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            code_reg <= seq_pkg::RESULT_RESET;
            trial_reg <= seq_pkg::RESULT_RESET;
        end
        else if (sar.trial_start)
        begin
            code_reg <= MSB;
            trial_reg <= MSB;
        end
        else if (sar.trial_step && trial_reg != '0)
        begin
            code_reg <= (sar.cmp_above ? code_reg : code_reg & ~trial_reg) | (trial_reg >> 1); // [RULE1]
            trial_reg <= trial_reg >> 1;
        end
    end

    assign sar.dac_code = code_reg;

    property p_one_trial;
        @(posedge clk) disable iff (srst) $onehot0(trial_reg) and (sar.trial_start |=> trial_reg == MSB);
    endproperty
    a_one_trial: assert property (p_one_trial) else $error("trial bit corrupt"); // [RULE1]
endmodule // sar_engine

//--- core/adc_conversion_sequencer.sv
// register slave, conversion timing and result store of the converter
//
// Chosen here: register access over Avalon-MM and the address map.
module adc_conversion_sequencer (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [9:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic EXTERNAL_TRIGGER_PIN_N,
    input wire logic COMPARATOR_ABOVE,
    output logic [9:0] DAC_CODE,
    output logic [2:0] CHANNEL_SELECT,
    output logic SAMPLE_HOLD,
    output logic CONVERSION_END_INTERRUPT
);
    logic flag_reg;
    logic ie_reg;
    logic start_reg;
    logic scan_reg;
    logic cks_reg;
    logic [2:0] ch_reg;
    logic external_trigger_enable_reg;
    logic seen_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [7:0] low_byte_holding_latch_reg;
    seq_pkg::res_t data_reg [4];
    seq_pkg::state_t state_reg;
    seq_pkg::cnt_t cnt_reg;
    seq_pkg::cnt_t sync_next;
    logic [1:0] off_reg;
    logic [1:0] off_next;
    logic [2:0] chan_reg;
    logic first_reg;
    logic [2:0] presc_reg;
    logic [7:0] idx;
    logic [7:0] rbyte;
    logic wr_acc;
    logic csr_wr;
    logic trig_fell;
    logic trig_go;
    logic cmp_level;
    logic conv_end;
    logic last_chan;
    seq_pkg::cnt_t conv_len_reg;
    seq_pkg::cnt_t spl_len_reg;

    sar_if sar ();

    sar_engine u_engine (
        .clk(CLK),
        .srst(SRST),
        .sar(sar)
    );

    pin_sync u_trig_sync (
        .clk(CLK),
        .srst(SRST),
        .pin(EXTERNAL_TRIGGER_PIN_N),
        .level(),
        .fell(trig_fell)
    );

    pin_sync u_cmp_sync (
        .clk(CLK),
        .srst(SRST),
        .pin(COMPARATOR_ABOVE),
        .level(cmp_level),
        .fell()
    );

    // bus slave: one wait cycle, then the request is accepted
    assign idx = AVS_ADDRESS[9:2];
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
    assign AVS_READDATA = rdata_reg;
    assign wr_acc = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
    assign csr_wr = wr_acc && idx == seq_pkg::IDX_CSR;
    assign trig_go = external_trigger_enable_reg & trig_fell; // [RULE16]

    always_ff @(posedge CLK)
    begin
        if (SRST)
            ack_reg <= 1'b0;
        else
            ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
    end

    always_comb
    begin
        rbyte = 8'h00;
        if (seq_pkg::is_result(idx))
            rbyte = idx[0] ? low_byte_holding_latch_reg : data_reg[idx[2:1]][9:2]; // [RULE18]
        else if (idx == seq_pkg::IDX_CSR)
            rbyte = {flag_reg, ie_reg, start_reg, scan_reg, cks_reg, ch_reg};
        else if (idx == seq_pkg::IDX_TRIG)
            rbyte = {external_trigger_enable_reg, seq_pkg::TRIG_RSVD};
    end

    // read data and the low-byte latch are taken together, so the
    // two halves always come from the same conversion
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            rdata_reg <= 32'h00000000;
            low_byte_holding_latch_reg <= 8'h00;
        end
        else if (AVS_READ && !ack_reg)
        begin
            rdata_reg <= 32'(rbyte);
            if (seq_pkg::is_result(idx) && !idx[0])
                low_byte_holding_latch_reg <= {data_reg[idx[2:1]][1:0], seq_pkg::RESULT_PAD}; // [RULE19]
        end
    end

    // flag may only be cleared after a read has seen it set; the mark is
    // taken with the read data, so a flag set during the wait stays unseen
    always_ff @(posedge CLK)
    begin
        if (SRST)
            seen_reg <= 1'b0;
        else if (csr_wr)
            seen_reg <= 1'b0;
        else if (AVS_READ && !ack_reg && idx == seq_pkg::IDX_CSR && flag_reg)
            seen_reg <= 1'b1; // [RULE5]
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
            flag_reg <= 1'b0;
        else if (conv_end && (!scan_reg || last_chan))
            flag_reg <= 1'b1; // [RULE3] [RULE10]
        else if (csr_wr && !AVS_WRITEDATA[seq_pkg::CSR_FLAG] && seen_reg)
            flag_reg <= 1'b0; // [RULE5]
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            ie_reg <= 1'b0;
            scan_reg <= 1'b0;
            cks_reg <= 1'b0;
            ch_reg <= 3'h0;
            external_trigger_enable_reg <= 1'b0;
        end
        else
        begin
            if (csr_wr)
            begin
                ie_reg <= AVS_WRITEDATA[seq_pkg::CSR_IE];
                scan_reg <= AVS_WRITEDATA[seq_pkg::CSR_SCAN];
                cks_reg <= AVS_WRITEDATA[seq_pkg::CSR_CKS];
                ch_reg <= AVS_WRITEDATA[2:0];
            end
            if (wr_acc && idx == seq_pkg::IDX_TRIG)
                external_trigger_enable_reg <= AVS_WRITEDATA[seq_pkg::TRIG_ENABLE];
        end
    end

    // trigger set wins over a software clear in the same cycle
    always_ff @(posedge CLK)
    begin
        if (SRST)
            start_reg <= 1'b0;
        else if (trig_go)
            start_reg <= 1'b1; // [RULE16]
        else if (csr_wr)
            start_reg <= AVS_WRITEDATA[seq_pkg::CSR_START];
        else if (conv_end && !scan_reg)
            start_reg <= 1'b0; // [RULE2]
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
            presc_reg <= 3'h0;
        else
            presc_reg <= presc_reg + 3'h1;
    end

    // sampling delay depends on where the start falls in the prescaler;
    // the idle cycle that sees the start counts as its first cycle
    always_comb
    begin
        if (cks_reg)
            sync_next = seq_pkg::cnt_t'(seq_pkg::SYNC_MAX_FAST - 2 - int'(presc_reg[1:0]));
        else
            sync_next = seq_pkg::cnt_t'(seq_pkg::SYNC_MAX_SLOW - 2 - int'(presc_reg)); // [RULE12]
    end

    assign conv_end = state_reg == seq_pkg::ST_CONVERT && cnt_reg == '0 && start_reg;
    assign last_chan = off_reg == ch_reg[1:0];
    assign off_next = last_chan ? 2'h0 : off_reg + 2'h1;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_reg <= seq_pkg::ST_IDLE;
            cnt_reg <= '0;
            off_reg <= 2'h0;
            chan_reg <= 3'h0;
            first_reg <= 1'b1;
        end
        else if (!start_reg)
        begin
            state_reg <= seq_pkg::ST_IDLE; // [RULE11]
            off_reg <= 2'h0;
        end
        else
        begin
            unique case (state_reg)
                seq_pkg::ST_IDLE:
                begin
                    state_reg <= seq_pkg::ST_SYNC;
                    cnt_reg <= sync_next;
                    off_reg <= 2'h0;
                    first_reg <= 1'b1;
                    chan_reg <= scan_reg ? {ch_reg[2], 2'h0} : ch_reg; // [RULE7] [RULE17]
                end
                seq_pkg::ST_SYNC:
                begin
                    if (cnt_reg == '0)
                    begin
                        state_reg <= seq_pkg::ST_SAMPLE;
                        cnt_reg <= seq_pkg::cnt_t'((cks_reg ? seq_pkg::SPL_FAST : seq_pkg::SPL_SLOW) - 1); // [RULE13]
                    end
                    else
                        cnt_reg <= cnt_reg - 9'h001;
                end
                seq_pkg::ST_SAMPLE:
                begin
                    if (cnt_reg == '0)
                    begin
                        state_reg <= seq_pkg::ST_CONVERT;
                        if (first_reg)
                            cnt_reg <= seq_pkg::cnt_t'((cks_reg ? seq_pkg::TAIL_FIRST_FAST
                                : seq_pkg::TAIL_FIRST_SLOW) - 1); // [RULE14]
                        else
                            cnt_reg <= seq_pkg::cnt_t'((cks_reg ? seq_pkg::TAIL_LATER_FAST
                                : seq_pkg::TAIL_LATER_SLOW) - 1); // [RULE15]
                    end
                    else
                        cnt_reg <= cnt_reg - 9'h001;
                end
                seq_pkg::ST_CONVERT:
                begin
                    if (cnt_reg != '0)
                        cnt_reg <= cnt_reg - 9'h001;
                    else if (!scan_reg)
                        state_reg <= seq_pkg::ST_IDLE; // [RULE3]
                    else
                    begin
                        // next channel skips the sampling delay
                        state_reg <= seq_pkg::ST_SAMPLE; // [RULE8] [RULE10]
                        cnt_reg <= seq_pkg::cnt_t'((cks_reg ? seq_pkg::SPL_FAST : seq_pkg::SPL_SLOW) - 1);
                        first_reg <= 1'b0;
                        off_reg <= off_next;
                        chan_reg <= {ch_reg[2], off_next};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            for (int i = 0; i < 4; i++)
                data_reg[i] <= seq_pkg::RESULT_RESET;
        end
        else if (conv_end)
            data_reg[chan_reg[1:0]] <= sar.dac_code; // [RULE3] [RULE9]
    end

    // trial bits are spaced so the comparator clears its synchroniser
    assign sar.trial_start = state_reg == seq_pkg::ST_SAMPLE && cnt_reg == '0;
    assign sar.trial_step = state_reg == seq_pkg::ST_CONVERT
        && (cnt_reg & (cks_reg ? seq_pkg::STEP_MASK_FAST : seq_pkg::STEP_MASK_SLOW)) == '0;
    assign sar.cmp_above = cmp_level;
    assign DAC_CODE = sar.dac_code;
    assign CHANNEL_SELECT = chan_reg;
    assign SAMPLE_HOLD = state_reg == seq_pkg::ST_SAMPLE;
    assign CONVERSION_END_INTERRUPT = flag_reg & ie_reg; // [RULE4] [RULE21]

    // helper counters for the timing checks
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            conv_len_reg <= '0;
            spl_len_reg <= '0;
        end
        else
        begin
            if (state_reg == seq_pkg::ST_IDLE)
                conv_len_reg <= 9'h002;
            else if (conv_end)
                conv_len_reg <= 9'h001;
            else
                conv_len_reg <= conv_len_reg + 9'h001;
            if (state_reg != seq_pkg::ST_SAMPLE)
                spl_len_reg <= 9'h001;
            else
                spl_len_reg <= spl_len_reg + 9'h001;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    property p_sync_range;
        (state_reg == seq_pkg::ST_SYNC && cnt_reg == '0 && start_reg) |-> (cks_reg
            ? conv_len_reg >= seq_pkg::SYNC_MIN_FAST && conv_len_reg <= seq_pkg::SYNC_MAX_FAST
            : conv_len_reg >= seq_pkg::SYNC_MIN_SLOW && conv_len_reg <= seq_pkg::SYNC_MAX_SLOW);
    endproperty
    a_sync_range: assert property (p_sync_range) else $error("sync delay out of range"); // [RULE12]

    property p_sample_len;
        (SAMPLE_HOLD && cnt_reg == '0 && start_reg)
            |-> spl_len_reg == (cks_reg ? seq_pkg::SPL_FAST : seq_pkg::SPL_SLOW);
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sampling length wrong"); // [RULE13]

    property p_first_len;
        (conv_end && first_reg) |-> (cks_reg
            ? conv_len_reg >= seq_pkg::CONV_MIN_FAST && conv_len_reg <= seq_pkg::CONV_MAX_FAST
            : conv_len_reg >= seq_pkg::CONV_MIN_SLOW && conv_len_reg <= seq_pkg::CONV_MAX_SLOW);
    endproperty
    a_first_len: assert property (p_first_len) else $error("first conversion length wrong"); // [RULE14]

    property p_later_len;
        (conv_end && !first_reg)
            |-> conv_len_reg == (cks_reg ? seq_pkg::LATER_FAST : seq_pkg::LATER_SLOW);
    endproperty
    a_later_len: assert property (p_later_len) else $error("later conversion length wrong"); // [RULE15]

    property p_single_end;
        (conv_end && !scan_reg && !trig_go && !csr_wr) |=> !start_reg && flag_reg
            && state_reg == seq_pkg::ST_IDLE && data_reg[$past(chan_reg[1:0])] == $past(sar.dac_code);
    endproperty
    a_single_end: assert property (p_single_end) else $error("single end sequence wrong"); // [RULE3]

    property p_irq_rise;
        ($rose(flag_reg) && ie_reg) |-> CONVERSION_END_INTERRUPT;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt not raised"); // [RULE4]

    property p_irq_drop;
        (!flag_reg || !ie_reg) |-> !CONVERSION_END_INTERRUPT;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("interrupt without cause"); // [RULE21]

    property p_flag_cause;
        $rose(flag_reg) |-> $past(conv_end) && (!$past(scan_reg) || $past(last_chan));
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set without pass end"); // [RULE10]

    property p_flag_clear;
        $fell(flag_reg) |-> $past(csr_wr) && $past(seen_reg);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag cleared without read"); // [RULE5]

    property p_scan_first;
        (state_reg == seq_pkg::ST_IDLE && start_reg && scan_reg)
            |=> off_reg == 2'h0 && chan_reg == {$past(ch_reg[2]), 2'h0};
    endproperty
    a_scan_first: assert property (p_scan_first) else $error("scan not at first channel"); // [RULE7]

    property p_scan_next;
        (conv_end && scan_reg && !last_chan && !csr_wr)
            |=> SAMPLE_HOLD && off_reg == 2'($past(off_reg) + 2'h1);
    endproperty
    a_scan_next: assert property (p_scan_next) else $error("scan did not advance"); // [RULE8]

    property p_trig_start;
        trig_go |=> start_reg;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger did not start"); // [RULE16]
endmodule // adc_conversion_sequencer

//--- sim/analog_model.sv
// comparator and fixed input levels standing in for the analog front end
module analog_model (
    input wire logic [2:0] ch,
    input wire logic [9:0] dac,
    output logic above
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] level;
    // distinct level per input so a result in the wrong register shows
    assign level = 10'h155 + 10'(10'h047 * ch);
    assign above = level >= dac;
endmodule // analog_model

//--- sim/tb.sv
// self-checking bench: bus tasks and conversion scenarios
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, srst, rd, wr, trig_n, above, wreq, sh, irq;
    logic [9:0] addr, dac;
    logic [31:0] wdata, rdata, d;
    logic [3:0] be;
    logic [2:0] chan;
    int fails, comparisons, n0, n1, n2;

    adc_conversion_sequencer u_adc_conversion_sequencer (.CLK(clk), .SRST(srst),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
        .EXTERNAL_TRIGGER_PIN_N(trig_n), .COMPARATOR_ABOVE(above), .DAC_CODE(dac),
        .CHANNEL_SELECT(chan), .SAMPLE_HOLD(sh), .CONVERSION_END_INTERRUPT(irq));
    analog_model u_analog_model (.ch(chan), .dac(dac), .above(above));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic summarize();
        $display("counts: comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // entered at a rising edge; leaves one idle edge so requests never merge
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] v,
        output logic [31:0] q);
        int i;
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= {24'h0, v};
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (wreq === 1'b0)
                break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 20)
        begin
            fails++;
            summarize();
        end
        @(posedge clk);
    endtask

    task automatic wr8(input logic [9:0] a, input logic [7:0] v);
        bus(1'b1, a, v, d);
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [31:0] exp, input string msg);
        bus(1'b0, a, 8'h00, d);
        check(d, exp, msg);
    endtask

    // k: 0 sample high, 1 sample low, 2 interrupt high; counts edges
    task automatic wait_for(input int k, output int n);
        for (n = 1; n < 2000; n++)
        begin
            @(posedge clk);
            if ((k == 0 && sh === 1'b1) || (k == 1 && sh === 1'b0) || (k == 2 && irq === 1'b1))
                break;
        end
        if (n == 2000)
        begin
            fails++;
            summarize();
        end
    endtask

    function automatic logic [31:0] res(input int n, input bit lo);
        logic [9:0] v;
        v = 10'h155 + 10'(10'h047 * n);
        return lo ? {24'h0, v[1:0], 6'h00} : {24'h0, v[9:2]};
    endfunction

    initial
    begin
        srst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = 10'h000;
        wdata = 32'h0;
        be = 4'h1;
        trig_n = 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdchk(10'h3a0, 32'h00, "csr reset");
        rdchk(10'h3a4, 32'h7f, "trigger reset");
        rdchk(10'h380, 32'h00, "result reset");
        wr8(10'h3fc, 8'hff);
        rdchk(10'h3fc, 32'h00, "unmapped");
        be <= 4'h0;
        wr8(10'h3a4, 8'h80);
        be <= 4'h1;
        rdchk(10'h3a4, 32'h7f, "byte lane off ignored");
        $display("test reset done");
        wr8(10'h3a0, 8'h61);
        wait_for(0, n0);
        check(chan, 3'h1, "single channel");
        wait_for(1, n1);
        check(n1, 80, "sample width");
        wait_for(2, n2);
        n0 = n0 + n1 + n2;
        check(n0 >= 259 && n0 <= 266, 1, "single length");
        wr8(10'h3a0, 8'h41);
        check(irq, 1'b1, "flag kept without read");
        rdchk(10'h3a0, 32'hc1, "flag set, start cleared");
        wr8(10'h3a0, 8'h41);
        check(irq, 1'b0, "interrupt drops");
        wr8(10'h3a0, 8'hc1);
        rdchk(10'h3a0, 32'h41, "flag one ignored");
        rdchk(10'h388, res(1, 0), "single high");
        $display("test single done");
        wr8(10'h3a0, 8'h3d);
        wait_for(0, n0);
        check(chan, 3'h4, "scan first");
        wait_for(1, n1);
        wait_for(0, n1);
        check(chan, 3'h5, "scan second");
        wait_for(1, n1);
        wait_for(0, n2);
        check(n1 + n2, 128, "later length");
        check(chan, 3'h4, "scan wraps");
        wait_for(1, n1);
        wait_for(0, n1);
        check(chan, 3'h5, "second pass");
        rdchk(10'h3a0, 32'hbd, "scan flag");
        wr8(10'h3a0, 8'h1d);
        rdchk(10'h380, res(4, 0), "scan a high");
        rdchk(10'h384, res(4, 1), "scan a low");
        rdchk(10'h388, res(5, 0), "scan b high");
        wr8(10'h3a0, 8'h3d);
        wait_for(0, n0);
        check(chan, 3'h4, "restart first");
        wr8(10'h3a0, 8'h00);
        $display("test scan done");
        wr8(10'h3a4, 8'h80);
        rdchk(10'h3a4, 32'hff, "trigger enable");
        wr8(10'h3a0, 8'h42);
        trig_n <= 1'b0;
        repeat (8) @(posedge clk);
        trig_n <= 1'b1;
        rdchk(10'h3a0, 32'h62, "trigger sets start");
        wait_for(2, n2);
        rdchk(10'h3a0, 32'hc2, "one start per edge");
        rdchk(10'h390, res(2, 0), "trigger high");
        rdchk(10'h394, res(2, 1), "trigger low");
        $display("test trigger done");
        summarize();
    end
endmodule // tb
